/* rtl/radio_status_pkg.sv */
// constants for the radio interrupt, supply regulator and battery monitor registers
// assumes byte-wide registers on a 9-bit register address
package radio_status_pkg;

	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = 9'h14E;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_PENDING = 9'h14F;
	localparam logic [ADDR_W-1:0] ADDR_SUPPLY_CTRL = 9'h150;
	localparam logic [ADDR_W-1:0] ADDR_BATTERY     = 9'h151;

	// pending / enable flag positions
	localparam int FLAG_WAKE        = 7;
	localparam int FLAG_TX_DONE     = 6;
	localparam int FLAG_ADDR_MATCH  = 5;
	localparam int FLAG_CHAN_ASSESS = 4;
	localparam int FLAG_RX_DONE     = 3;
	localparam int FLAG_RX_START    = 2;
	localparam int FLAG_SYNTH_UNLK  = 1;
	localparam int FLAG_SYNTH_LOCK  = 0;

	// supply regulator control fields
	localparam int SUP_ANALOG_EXT   = 7;
	localparam int SUP_ANALOG_READY = 6;
	localparam int SUP_ANALOG_TRIM  = 4;
	localparam int SUP_DIGITAL_EXT  = 3;
	localparam int SUP_DIGITAL_RDY  = 2;
	localparam int SUP_DIGITAL_TRIM = 0;
	localparam int TRIM_W           = 2;

	// battery monitor fields
	localparam int BATTERY_LOW_FLAG_FLAG     = 7;
	localparam int BATTERY_LOW_FLAG_IRQ_EN   = 6;
	localparam int BAT_ABOVE_THR    = 5;
	localparam int BAT_RANGE_SEL    = 4;
	localparam int BAT_THR_SEL      = 0;
	localparam int THR_W            = 4;

	// reset values
	localparam logic [DATA_W-1:0] RST_IRQ_ENABLE  = 8'h00;
	localparam logic [DATA_W-1:0] RST_IRQ_PENDING = 8'h00;
	localparam logic [TRIM_W-1:0] RST_TRIM        = 2'h0;
	localparam logic [THR_W-1:0]  RST_THRESHOLD   = 4'h2;
	localparam logic [DATA_W-1:0] READ_IDLE       = 8'h00;

	// trim encodings of the supply level
	localparam logic [TRIM_W-1:0] TRIM_1V80 = 2'h0;
	localparam logic [TRIM_W-1:0] TRIM_1V75 = 2'h1;
	localparam logic [TRIM_W-1:0] TRIM_1V84 = 2'h2;
	localparam logic [TRIM_W-1:0] TRIM_1V88 = 2'h3;

endpackage

/* rtl/radio_status_regs.sv */
// radio interrupt pending/enable, supply regulator control and battery monitor registers
// assumes register strobes and radio events on core_clk; analog status inputs are asynchronous
`timescale 1ns/1ps

module radio_status_regs
	import radio_status_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [DATA_W-1:0] regRdData,
	input  wire logic [DATA_W-1:0] radioEvent,
	input  wire logic [DATA_W-1:0] radioServiceAck,
	input  wire logic              batteryServiceAck,
	input  wire logic              analogSettledAsync,
	input  wire logic              digitalSettledAsync,
	input  wire logic              batteryAboveAsync,
	output logic      [DATA_W-1:0] radioIrqReq,
	output logic                   batteryIrqReq,
	output logic                   analogRegOff,
	output logic      [TRIM_W-1:0] analogSupplyTrim,
	output logic      [TRIM_W-1:0] digitalSupplyTrim,
	output logic                   batteryRangeSel,
	output logic      [THR_W-1:0]  batteryThresholdSel
);

	logic [DATA_W-1:0] pending_q;
	logic [DATA_W-1:0] enable_q;
	logic              analogExt_q;
	logic              digitalExt_q;
	logic [TRIM_W-1:0] analogTrim_q;
	logic [TRIM_W-1:0] digitalTrim_q;
	logic              batLow_q;
	logic              batLowEn_q;
	logic              batRange_q;
	logic [THR_W-1:0]  batThr_q;
	logic [2:0]        syncA_q;
	logic [2:0]        syncB_q;
	logic [2:0]        syncC_q;
	logic              batAbovePrev_q;
	logic [DATA_W-1:0] regRdData_q;
	logic [DATA_W-1:0] radioIrqReq_q;
	logic              batteryIrqReq_q;
	logic [DATA_W-1:0] readMux;
	logic              analogReady;
	logic              digitalReady;
	logic              batAbove;
	logic              batDrop;
	logic              wrPending;
	logic              wrSupply;
	logic              wrBattery;
	logic              wrEnable;

	assign wrPending = regWrite && (regAddr == ADDR_IRQ_PENDING);
	assign wrSupply  = regWrite && (regAddr == ADDR_SUPPLY_CTRL);
	assign wrBattery = regWrite && (regAddr == ADDR_BATTERY);
	assign wrEnable  = regWrite && (regAddr == ADDR_IRQ_ENABLE);

	// two-stage synchronisers; syncA_q is first stage, only read by syncB_q
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
		end else begin
			syncA_q <= {batteryAboveAsync, digitalSettledAsync, analogSettledAsync};
			syncB_q <= syncA_q;
		end
	end

	// syncC_q aliases syncB_q; bits 0, 1, 2 carry analog, digital and battery status
	assign syncC_q = syncB_q;

	// analog regulator off means not ready unless external supply selected
	assign analogReady  = analogExt_q | (syncC_q[0] & ~analogExt_q);
	// internal digital regulator stays on whatever the external bit says
	assign digitalReady = digitalExt_q | syncC_q[1];
	assign batAbove     = syncC_q[2];
	assign batDrop      = batAbovePrev_q & ~batAbove;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			batAbovePrev_q <= 1'b0;
		end else begin
			batAbovePrev_q <= batAbove;
		end
	end

	// pending flags: new event beats a same-cycle clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pending_q <= RST_IRQ_PENDING;
		end else begin
			pending_q <= (pending_q
				& ~(wrPending ? regWrData : READ_IDLE)
				& ~radioServiceAck)
				| radioEvent;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			enable_q <= RST_IRQ_ENABLE;
		end else if (wrEnable) begin
			enable_q <= regWrData;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			analogExt_q   <= 1'b0;
			digitalExt_q  <= 1'b0;
			analogTrim_q  <= RST_TRIM;
			digitalTrim_q <= RST_TRIM;
		end else if (wrSupply) begin
			// ready bits 6 and 2 are not stored
			analogExt_q   <= regWrData[SUP_ANALOG_EXT];
			digitalExt_q  <= regWrData[SUP_DIGITAL_EXT];
			analogTrim_q  <= regWrData[SUP_ANALOG_TRIM +: TRIM_W];
			digitalTrim_q <= regWrData[SUP_DIGITAL_TRIM +: TRIM_W];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			batLowEn_q <= 1'b0;
			batRange_q <= 1'b0;
			batThr_q   <= RST_THRESHOLD;
		end else if (wrBattery) begin
			batLowEn_q <= regWrData[BATTERY_LOW_FLAG_IRQ_EN];
			batRange_q <= regWrData[BAT_RANGE_SEL];
			batThr_q   <= regWrData[BAT_THR_SEL +: THR_W];
		end
	end

	// battery low flag set on a drop below threshold; set beats clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			batLow_q <= 1'b0;
		end else begin
			batLow_q <= (batLow_q
				& ~(wrBattery & regWrData[BATTERY_LOW_FLAG_FLAG])
				& ~batteryServiceAck)
				| batDrop;
		end
	end

	always_comb begin
		readMux = READ_IDLE;
		unique case (regAddr)
			ADDR_IRQ_ENABLE:  readMux = enable_q;
			ADDR_IRQ_PENDING: readMux = pending_q;
			ADDR_SUPPLY_CTRL: readMux = {analogExt_q, analogReady, analogTrim_q,
				digitalExt_q, digitalReady, digitalTrim_q};
			ADDR_BATTERY:     readMux = {batLow_q, batLowEn_q, batAbove, batRange_q,
				batThr_q};
			default:          readMux = READ_IDLE;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData_q <= READ_IDLE;
		end else begin
			regRdData_q <= regRead ? readMux : READ_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			radioIrqReq_q   <= RST_IRQ_PENDING;
			batteryIrqReq_q <= 1'b0;
		end else begin
			radioIrqReq_q   <= pending_q & enable_q;
			batteryIrqReq_q <= batLow_q & batLowEn_q;
		end
	end

	assign regRdData           = regRdData_q;
	assign radioIrqReq         = radioIrqReq_q;
	assign batteryIrqReq       = batteryIrqReq_q;
	assign analogRegOff        = analogExt_q;
	assign analogSupplyTrim    = analogTrim_q;
	assign digitalSupplyTrim   = digitalTrim_q;
	assign batteryRangeSel     = batRange_q;
	assign batteryThresholdSel = batThr_q;

	a_event_sets_flag: assert property (@(posedge core_clk) disable iff (!rstn)
		(|radioEvent) |=> ((pending_q & $past(radioEvent)) == $past(radioEvent)))
		else $error("radio event did not set its pending flag");

	a_write_one_clears: assert property (@(posedge core_clk) disable iff (!rstn)
		(wrPending && radioEvent == 8'h00 && radioServiceAck == 8'h00)
		|=> pending_q == ($past(pending_q) & ~$past(regWrData)))
		else $error("pending write did not clear exactly the ones written");

	a_service_clears: assert property (@(posedge core_clk) disable iff (!rstn)
		(!wrPending && radioEvent == 8'h00)
		|=> pending_q == ($past(pending_q) & ~$past(radioServiceAck)))
		else $error("service acknowledge did not clear its flag");

	a_irq_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		##1 radioIrqReq == ($past(pending_q) & $past(enable_q)))
		else $error("radio request differs from flag and enable");

	a_analog_off: assert property (@(posedge core_clk) disable iff (!rstn)
		wrSupply |=> analogRegOff == $past(regWrData[SUP_ANALOG_EXT]))
		else $error("analog regulator off does not follow written bit");

	a_analog_ready: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && analogExt_q)
		|=> regRdData[SUP_ANALOG_READY])
		else $error("analog ready not forced by external supply bit");

	a_digital_ready: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && digitalExt_q)
		|=> regRdData[SUP_DIGITAL_RDY])
		else $error("digital ready not forced by external supply bit");

	a_battery_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		!batLowEn_q |=> !batteryIrqReq)
		else $error("battery request raised while disabled");

	a_battery_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		(wrBattery && regWrData[BATTERY_LOW_FLAG_FLAG] && !batDrop) |=> !batLow_q)
		else $error("battery low flag not cleared by write of one");

	a_trim_stored: assert property (@(posedge core_clk) disable iff (!rstn)
		wrSupply |=> (analogSupplyTrim == $past(regWrData[SUP_ANALOG_TRIM +: TRIM_W])
			&& digitalSupplyTrim == $past(regWrData[SUP_DIGITAL_TRIM +: TRIM_W])))
		else $error("trim fields not stored");

	a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
		!regRead |=> regRdData == 8'h00)
		else $error("read data present without read strobe");

	a_write_zero_keeps: assert property (@(posedge core_clk) disable iff (!rstn)
		(wrPending && radioServiceAck == 8'h00)
		|=> (pending_q & ~$past(regWrData))
			== (($past(pending_q) | $past(radioEvent)) & ~$past(regWrData)))
		else $error("pending write of zero changed a flag");

	a_no_spurious_flag: assert property (@(posedge core_clk) disable iff (!rstn)
		1'b1 |=> (pending_q & ~$past(pending_q) & ~$past(radioEvent)) == 8'h00)
		else $error("pending flag rose without its event");

	a_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		(!wrPending && radioServiceAck == 8'h00)
		|=> (pending_q & $past(pending_q)) == $past(pending_q))
		else $error("pending flag dropped without a clear");

	a_ack_only_own: assert property (@(posedge core_clk) disable iff (!rstn)
		!wrPending
		|=> (pending_q & ~$past(radioServiceAck))
			== (($past(pending_q) | $past(radioEvent)) & ~$past(radioServiceAck)))
		else $error("service acknowledge touched another flag");

	a_enable_write: assert property (@(posedge core_clk) disable iff (!rstn)
		wrEnable |=> enable_q == $past(regWrData))
		else $error("enable register not written");

	a_enable_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		!wrEnable |=> $stable(enable_q))
		else $error("enable register changed without a write");

	a_pending_read: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_IRQ_PENDING)
		|=> regRdData == $past(pending_q))
		else $error("pending read data differs from flags");

	a_enable_read: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_IRQ_ENABLE)
		|=> regRdData == $past(enable_q))
		else $error("enable read data differs from register");

	a_supply_fields: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL)
		|=> (regRdData[SUP_ANALOG_EXT] == $past(analogExt_q)
			&& regRdData[SUP_DIGITAL_EXT] == $past(digitalExt_q)))
		else $error("supply select bits read back wrong");

	a_trim_readback: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL)
		|=> (regRdData[SUP_ANALOG_TRIM +: TRIM_W] == $past(analogTrim_q)
			&& regRdData[SUP_DIGITAL_TRIM +: TRIM_W] == $past(digitalTrim_q)))
		else $error("trim fields read back wrong");

	a_analog_unready: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && !analogExt_q && !syncC_q[0])
		|=> !regRdData[SUP_ANALOG_READY])
		else $error("analog ready set while supply unsettled");

	a_analog_settled: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && syncC_q[0])
		|=> regRdData[SUP_ANALOG_READY])
		else $error("analog ready clear while supply settled");

	a_digital_settled: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && syncC_q[1])
		|=> regRdData[SUP_DIGITAL_RDY])
		else $error("digital ready clear while supply settled");

	a_digital_unready: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_SUPPLY_CTRL && !digitalExt_q && !syncC_q[1])
		|=> !regRdData[SUP_DIGITAL_RDY])
		else $error("digital ready set while supply unsettled");

	a_digital_ext_stored: assert property (@(posedge core_clk) disable iff (!rstn)
		wrSupply |=> digitalExt_q == $past(regWrData[SUP_DIGITAL_EXT]))
		else $error("digital external bit not stored");

	a_supply_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		!wrSupply
		|=> ($stable(analogRegOff) && $stable(analogSupplyTrim) && $stable(digitalSupplyTrim)))
		else $error("supply outputs changed without a write");

	a_battery_fields: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_BATTERY)
		|=> (regRdData[BAT_ABOVE_THR] == $past(batAbove)
			&& regRdData[BATTERY_LOW_FLAG_FLAG] == $past(batLow_q)))
		else $error("battery status bits read back wrong");

	a_battery_cfg_read: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr == ADDR_BATTERY)
		|=> (regRdData[BAT_THR_SEL +: THR_W] == $past(batThr_q)
			&& regRdData[BAT_RANGE_SEL] == $past(batRange_q)
			&& regRdData[BATTERY_LOW_FLAG_IRQ_EN] == $past(batLowEn_q)))
		else $error("battery settings read back wrong");

	a_battery_set: assert property (@(posedge core_clk) disable iff (!rstn)
		batDrop |=> batLow_q)
		else $error("battery drop did not set the low flag");

	a_battery_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		(!batDrop && !batteryServiceAck && !(wrBattery && regWrData[BATTERY_LOW_FLAG_FLAG]))
		|=> batLow_q == $past(batLow_q))
		else $error("battery low flag changed without cause");

	a_battery_service: assert property (@(posedge core_clk) disable iff (!rstn)
		(batteryServiceAck && !batDrop) |=> !batLow_q)
		else $error("battery service did not clear the low flag");

	a_battery_req: assert property (@(posedge core_clk) disable iff (!rstn)
		(batLow_q && batLowEn_q) |=> batteryIrqReq)
		else $error("battery request missing with flag and enable");

	a_range_stored: assert property (@(posedge core_clk) disable iff (!rstn)
		wrBattery |=> batteryRangeSel == $past(regWrData[BAT_RANGE_SEL]))
		else $error("battery range bit not stored");

	a_threshold_stored: assert property (@(posedge core_clk) disable iff (!rstn)
		wrBattery |=> batteryThresholdSel == $past(regWrData[BAT_THR_SEL +: THR_W]))
		else $error("battery threshold not stored");

	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rstn)
		(regRead && regAddr != ADDR_IRQ_ENABLE && regAddr != ADDR_IRQ_PENDING
			&& regAddr != ADDR_SUPPLY_CTRL && regAddr != ADDR_BATTERY)
		|=> regRdData == READ_IDLE)
		else $error("unmapped address read back nonzero");

endmodule // radio_status_regs

/* bench/test_radio_status_regs.sv */
// self-checking bench for the radio interrupt, supply and battery register block
// assumes radio_status_pkg and radio_status_regs from rtl/ are compiled first
`timescale 1ns/1ps
module test_radio_status_regs
	import radio_status_pkg::*;
;
	logic              core_clk, rstn, regWrite, regRead, batteryServiceAck;
	logic              analogSettledAsync, digitalSettledAsync, batteryAboveAsync;
	logic              batteryIrqReq, analogRegOff, batteryRangeSel;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData, radioEvent, radioServiceAck, radioIrqReq;
	logic [TRIM_W-1:0] analogSupplyTrim, digitalSupplyTrim;
	logic [THR_W-1:0]  batteryThresholdSel;
	int                nErrors, testsRun;
	radio_status_regs dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .radioEvent(radioEvent), .radioServiceAck(radioServiceAck),
		.batteryServiceAck(batteryServiceAck), .analogSettledAsync(analogSettledAsync),
		.digitalSettledAsync(digitalSettledAsync), .batteryAboveAsync(batteryAboveAsync),
		.radioIrqReq(radioIrqReq), .batteryIrqReq(batteryIrqReq),
		.analogRegOff(analogRegOff), .analogSupplyTrim(analogSupplyTrim),
		.digitalSupplyTrim(digitalSupplyTrim), .batteryRangeSel(batteryRangeSel),
		.batteryThresholdSel(batteryThresholdSel));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic stopTest;
		$display("checks %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		chk("regRdData", regRdData, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pulseEv(input logic [7:0] ev, input logic [7:0] ack);
		@(posedge core_clk);
		radioEvent      <= ev;
		radioServiceAck <= ack;
		@(posedge core_clk);
		radioEvent      <= 8'h00;
		radioServiceAck <= 8'h00;
	endtask
	task automatic setAbove(input logic v);
		@(posedge core_clk);
		batteryAboveAsync <= v;
		tick(5);
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		nErrors++;
		stopTest;
	end

	initial begin
		{rstn, regWrite, regRead, batteryServiceAck} = 4'h0;
		{analogSettledAsync, digitalSettledAsync, batteryAboveAsync} = 3'h0;
		{regAddr, regWrData, radioEvent, radioServiceAck} = '0;
		{nErrors, testsRun} = '0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		rd(ADDR_IRQ_ENABLE, 8'h00);
		rd(ADDR_IRQ_PENDING, 8'h00);
		rd(ADDR_SUPPLY_CTRL, 8'h00);
		rd(ADDR_BATTERY, 8'h02);
		for (int i = 0; i < 8; i++) begin
			pulseEv(8'h01 << i, 8'h00);
			wr(ADDR_IRQ_PENDING, ~(8'h01 << i));
			rd(ADDR_IRQ_PENDING, 8'h01 << i);
			wr(ADDR_IRQ_PENDING, 8'h01 << i);
			rd(ADDR_IRQ_PENDING, 8'h00);
		end
		rd(ADDR_IRQ_PENDING, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h0F);
		rd(ADDR_IRQ_ENABLE, 8'h0F);
		pulseEv(8'hFF, 8'h00);
		tick(1);
		chk("radioIrqReq", radioIrqReq, 8'h0F);
		pulseEv(8'h00, 8'h05);
		rd(ADDR_IRQ_PENDING, 8'hFA);
		wr(ADDR_IRQ_PENDING, 8'hF0);
		rd(ADDR_IRQ_PENDING, 8'h0A);
		chk("radioIrqReq", radioIrqReq, 8'h0A);
		// external selects force both ready bits while supplies are unsettled
		wr(ADDR_SUPPLY_CTRL, 8'h88);
		rd(ADDR_SUPPLY_CTRL, 8'hCC);
		chk("analogRegOff", 8'(analogRegOff), 8'h01);
		wr(ADDR_SUPPLY_CTRL, 8'h44);
		rd(ADDR_SUPPLY_CTRL, 8'h00);
		chk("analogRegOff", 8'(analogRegOff), 8'h00);
		@(posedge core_clk);
		{analogSettledAsync, digitalSettledAsync} <= 2'b11;
		tick(3);
		for (int t = 0; t < 4; t++) begin
			wr(ADDR_SUPPLY_CTRL, {2'b00, 2'(t), 2'b00, 2'(t)});
			rd(ADDR_SUPPLY_CTRL, {2'b01, 2'(t), 2'b01, 2'(t)});
			chk("analogSupplyTrim", 8'(analogSupplyTrim), 8'(t));
			chk("digitalSupplyTrim", 8'(digitalSupplyTrim), 8'(t));
		end
		wr(ADDR_BATTERY, 8'h7F);
		rd(ADDR_BATTERY, 8'h5F);
		chk("batteryRangeSel", 8'(batteryRangeSel), 8'h01);
		chk("batteryThresholdSel", 8'(batteryThresholdSel), 8'h0F);
		setAbove(1'b1);
		rd(ADDR_BATTERY, 8'h7F);
		setAbove(1'b0);
		rd(ADDR_BATTERY, 8'hDF);
		chk("batteryIrqReq", 8'(batteryIrqReq), 8'h01);
		wr(ADDR_BATTERY, 8'h9F);
		rd(ADDR_BATTERY, 8'h1F);
		setAbove(1'b1);
		setAbove(1'b0);
		rd(ADDR_BATTERY, 8'h9F);
		chk("batteryIrqReq", 8'(batteryIrqReq), 8'h00);
		@(posedge core_clk);
		batteryServiceAck <= 1'b1;
		@(posedge core_clk);
		batteryServiceAck <= 1'b0;
		rd(ADDR_BATTERY, 8'h1F);
		tick(1);
		chk("regRdData", regRdData, 8'h00);
		wr(9'h152, 8'hFF);
		rd(9'h152, 8'h00);
		stopTest;
	end
endmodule // test_radio_status_regs
